// *** design/twe_defs.vh ***
// constants for the two-wire memory write slave
//
// Behaviour
// - sample data on clock rise, drive after fall
// - data line only pulled low or released
// - open strap inputs count as low
// - protect input high blocks all programming
// - array is 32 pages of 16 bytes
// - data changes only while clock is low
// - data falling with clock high is start
// - data rising with clock high is stop
// - stop after write starts program cycle
// - acknowledge low on ninth clock per byte
// - standby after reset, read stop, programming
// - device type prefix 1010 must match
// - bits five, six match straps, else standby
// - seventh address bit is page high bit
// - last address bit selects read or write
// - byte write: address, word address, data, stop
// - program cycle ignores every bus input
// - program cycle lasts at most 5 ms
// - page write acknowledges each further data byte
// - only low four column bits increment
// - column wraps inside page past sixteen bytes
// - no acknowledge while programming, normal after
`ifndef TWE_DEFS_VH
`define TWE_DEFS_VH

// device address word layout
`define TWE_DEV_TYPE      4'hA
`define TWE_TYPE_MSB      7
`define TWE_TYPE_LSB      4
`define TWE_CS_HI_BIT     3
`define TWE_CS_LO_BIT     2
`define TWE_PAGE_BIT      1
`define TWE_RW_BIT        0

// bit counter positions inside one byte slot
`define TWE_LAST_DATA_CNT 4'h7
`define TWE_ACK_CNT       4'h8
`define TWE_ACK_END_CNT   4'h9
`define TWE_CNT_ZERO      4'h0

// array geometry
`define TWE_PAGES         32
`define TWE_PAGE_BYTES    16
`define TWE_ADDR_W        9
`define TWE_COL_W         4
`define TWE_ROW_W         5
`define TWE_BYTE_W        8

// timing: program cycle time in ms, clock period in ns
`define TWE_PROG_TIME_MS  5
`define TWE_NS_PER_MS     1000000
`define TWE_CLK_PERIOD_NS 5

// reset values
`define TWE_BYTE_RST      8'h00
`define TWE_ADDR_RST      9'h000
`define TWE_COL_RST       4'h0
`define TWE_MASK_RST      16'h0000

`endif

// *** design/twe_fifo2.v ***
// small valid/ready buffer standing in the received data path
`timescale 1ns/10ps
module twe_fifo2 #(
   parameter W     = 12,
   parameter DEPTH = 2,
   parameter AW    = 1
) (
   // clock and reset
   input  wire          mclk,
   input  wire          resetn,
   input  wire          ce,
   // fill side
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   // drain side
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data
);

   reg [W-1:0]  mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0]   count_r;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   // full and empty come straight from the occupancy count
   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rd_ptr_r];

   // storage has no reset; only entries counted valid are ever read
   always @(posedge mclk) begin
      if (ce && push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers wrap at depth, so depth need not be a power of two
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

// *** design/twe_slave.v ***
// two-wire serial write slave of a 512-byte nonvolatile array
`timescale 1ns/10ps
`include "twe_defs.vh"
module twe_slave #(
   parameter PROG_CYCLES = `TWE_PROG_TIME_MS * `TWE_NS_PER_MS / `TWE_CLK_PERIOD_NS,
   parameter CNT_W       = 20,
   parameter BUF_DEPTH   = 2
) (
   // clock, reset, enable
   input  wire                   mclk,
   input  wire                   resetn,
   input  wire                   ce,
   // serial bus pins
   input  wire                   scl_in,
   input  wire                   sda_in,
   output reg                    sda_out,
   output reg                    sda_oe,
   // straps and protection
   input  wire                   chip_select_strap_high,
   input  wire                   chip_select_strap_low,
   input  wire                   wp,
   // array inspection port
   input  wire [`TWE_ADDR_W-1:0] rd_addr,
   output reg  [`TWE_BYTE_W-1:0] rd_data_r,
   // status
   output reg                    standby_r,
   output reg                    busy_r,
   output reg                    read_mode_r
);

   // main states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_DEV  = 3'h1;
   localparam [2:0] ST_WADR = 3'h2;
   localparam [2:0] ST_DATA = 3'h3;
   localparam [2:0] ST_READ = 3'h4;
   localparam [2:0] ST_PROG = 3'h5;

   localparam FIFO_W = `TWE_COL_W + `TWE_BYTE_W;
   // reload value is cut to the counter width on purpose
   localparam [31:0]      PROG_LOAD_W = PROG_CYCLES - 1;
   localparam [CNT_W-1:0] PROG_LOAD   = PROG_LOAD_W[CNT_W-1:0];

   // two-flop synchronisers; the third stage only serves edge finding
   reg scl_s1_r, scl_s2_r, scl_s3_r;
   reg sda_s1_r, sda_s2_r, sda_s3_r;
   reg csh_s1_r, csh_s2_r;
   reg csl_s1_r, csl_s2_r;
   reg wp_s1_r,  wp_s2_r;

   // byte engine
   reg [3:0]             bit_cnt_r;
   reg [`TWE_BYTE_W-1:0] shift_r;
   reg                   ack_pend_r;

   // transaction context
   reg [2:0]             state_r;
   reg [2:0]             state_nxt;
   reg                   page_bit_r;
   reg [`TWE_ROW_W-1:0]  row_r;
   reg [`TWE_COL_W-1:0]  col_r;
   reg                   data_seen_r;
   reg [CNT_W-1:0]       prog_cnt_r;

   // page latch and load mask
   reg [`TWE_BYTE_W-1:0] page_r [0:`TWE_PAGE_BYTES-1];
   reg [`TWE_PAGE_BYTES-1:0] mask_r;

   // the array itself
   reg [`TWE_BYTE_W-1:0] mem_r [0:`TWE_PAGES*`TWE_PAGE_BYTES-1];

   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire byte_done;
   wire [`TWE_BYTE_W-1:0] byte_val;
   wire dev_match;
   wire prog_done;
   wire commit;
   wire fill_valid;
   wire fill_ready;
   wire drain_valid;
   wire drain_ready;
   wire [FIFO_W-1:0] drain_data;
   wire [`TWE_COL_W-1:0] drain_col;
   wire [`TWE_BYTE_W-1:0] drain_byte;
   integer i;

   // synchronise every pin before any logic looks at it
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_s3_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_s3_r <= 1'b1;
         csh_s1_r <= 1'b0;
         csh_s2_r <= 1'b0;
         csl_s1_r <= 1'b0;
         csl_s2_r <= 1'b0;
         wp_s1_r  <= 1'b0;
         wp_s2_r  <= 1'b0;
      end else if (ce) begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_s3_r <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_s3_r <= sda_s2_r;
         csh_s1_r <= chip_select_strap_high;
         csh_s2_r <= csh_s1_r;
         csl_s1_r <= chip_select_strap_low;
         csl_s2_r <= csl_s1_r;
         wp_s1_r  <= wp;
         wp_s2_r  <= wp_s1_r;
      end
   end

   // bus events; data moving under a high clock is start or stop
   assign scl_rise  = scl_s2_r & ~scl_s3_r;
   assign scl_fall  = ~scl_s2_r & scl_s3_r;
   assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
   assign bus_stop  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

   // a byte completes on the eighth rising edge
   assign byte_done = scl_rise & (bit_cnt_r == `TWE_LAST_DATA_CNT) & (bit_cnt_r < `TWE_ACK_CNT);
   assign byte_val  = {shift_r[`TWE_BYTE_W-2:0], sda_s2_r};

   // pins left open are pulled low on the board side, so a low strap matches zero
   assign dev_match = (byte_val[`TWE_TYPE_MSB:`TWE_TYPE_LSB] == `TWE_DEV_TYPE) &
                      (byte_val[`TWE_CS_HI_BIT] == csh_s2_r) &
                      (byte_val[`TWE_CS_LO_BIT] == csl_s2_r);

   // program cycle ends once the count is spent and no byte is still in flight
   assign prog_done = (state_r == ST_PROG) & (prog_cnt_r == {CNT_W{1'b0}});
   assign commit    = prog_done & ~drain_valid;

   // received data bytes enter the buffer tagged with their column
   assign fill_valid = byte_done & (state_r == ST_DATA);
   // the loader pauses in the commit cycle so the latch is stable while copied
   assign drain_ready = ~commit;
   assign drain_col   = drain_data[FIFO_W-1:`TWE_BYTE_W];
   assign drain_byte  = drain_data[`TWE_BYTE_W-1:0];

   twe_fifo2 #(
      .W     (FIFO_W),
      .DEPTH (BUF_DEPTH),
      .AW    (1)
   ) u_buf (
      .mclk      (mclk),
      .resetn    (resetn),
      .ce        (ce),
      .in_valid  (fill_valid),
      .in_ready  (fill_ready),
      .in_data   ({col_r, byte_val}),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_data)
   );

   // next state; while programming every bus event is ignored
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_PROG: begin
            if (commit) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            if (bus_start) begin
               state_nxt = ST_DEV;
            end else if (bus_stop) begin
               // only a write that loaded at least one byte programs
               if (state_r == ST_DATA && data_seen_r && !wp_s2_r) begin
                  state_nxt = ST_PROG;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end else if (byte_done) begin
               case (state_r)
                  ST_DEV: begin
                     if (!dev_match) begin
                        state_nxt = ST_IDLE;
                     end else if (byte_val[`TWE_RW_BIT]) begin
                        state_nxt = ST_READ;
                     end else begin
                        state_nxt = ST_WADR;
                     end
                  end
                  ST_WADR: begin
                     state_nxt = ST_DATA;
                  end
                  default: begin
                     state_nxt = state_r;
                  end
               endcase
            end
         end
      endcase
   end

   // state register and status outputs
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r     <= ST_IDLE;
         standby_r   <= 1'b1;
         busy_r      <= 1'b0;
         read_mode_r <= 1'b0;
      end else if (ce) begin
         state_r     <= state_nxt;
         standby_r   <= (state_nxt == ST_IDLE);
         busy_r      <= (state_nxt == ST_PROG);
         read_mode_r <= (state_nxt == ST_READ);
      end
   end

   // bit counter, shifter and acknowledge slot
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt_r  <= `TWE_CNT_ZERO;
         shift_r    <= `TWE_BYTE_RST;
         ack_pend_r <= 1'b0;
         sda_oe     <= 1'b0;
         sda_out    <= 1'b0;
      end else if (ce) begin
         sda_out <= 1'b0;
         if (state_r == ST_PROG) begin
            // nothing on the bus is seen until the cycle finishes
            bit_cnt_r  <= `TWE_CNT_ZERO;
            ack_pend_r <= 1'b0;
            sda_oe     <= 1'b0;
         end else if (bus_start || bus_stop) begin
            bit_cnt_r  <= `TWE_CNT_ZERO;
            ack_pend_r <= 1'b0;
            sda_oe     <= 1'b0;
         end else if (scl_rise) begin
            if (bit_cnt_r < `TWE_ACK_CNT) begin
               shift_r   <= byte_val;
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (bit_cnt_r == `TWE_ACK_CNT) begin
               bit_cnt_r <= `TWE_ACK_END_CNT;
            end
            if (byte_done) begin
               case (state_r)
                  ST_DEV:  ack_pend_r <= dev_match;
                  ST_WADR: ack_pend_r <= 1'b1;
                  ST_DATA: ack_pend_r <= fill_ready;
                  default: ack_pend_r <= 1'b0;
               endcase
            end
         end else if (scl_fall) begin
            // output changes only after a falling clock edge
            if (bit_cnt_r == `TWE_ACK_CNT) begin
               sda_oe <= ack_pend_r;
            end else if (bit_cnt_r == `TWE_ACK_END_CNT) begin
               sda_oe     <= 1'b0;
               ack_pend_r <= 1'b0;
               bit_cnt_r  <= `TWE_CNT_ZERO;
            end
         end
      end
   end

   // address context: page bit, row and wrapping column
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         page_bit_r  <= 1'b0;
         row_r       <= {`TWE_ROW_W{1'b0}};
         col_r       <= `TWE_COL_RST;
         data_seen_r <= 1'b0;
      end else if (ce) begin
         if (state_r != ST_PROG && bus_start) begin
            data_seen_r <= 1'b0;
         end else if (byte_done) begin
            case (state_r)
               ST_DEV: begin
                  page_bit_r <= byte_val[`TWE_PAGE_BIT];
               end
               ST_WADR: begin
                  // the page bit and the eight-bit word address split into row and column
                  row_r <= {page_bit_r, byte_val[`TWE_BYTE_W-1:`TWE_COL_W]};
                  col_r <= byte_val[`TWE_COL_W-1:0];
               end
               ST_DATA: begin
                  if (fill_ready) begin
                     // four-bit column rolls over inside the page
                     col_r       <= col_r + 4'h1;
                     data_seen_r <= 1'b1;
                  end
               end
               default: begin
                  col_r <= col_r;
               end
            endcase
         end
      end
   end

   // page latch loader; a later byte to the same column overwrites
   always @(posedge mclk) begin
      if (ce && drain_valid && drain_ready) begin
         page_r[drain_col] <= drain_byte;
      end
   end

   // load mask: cleared per new write, set per loaded column
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mask_r <= `TWE_MASK_RST;
      end else if (ce) begin
         if (commit || (byte_done && state_r == ST_DEV)) begin
            mask_r <= `TWE_MASK_RST;
         end else if (drain_valid && drain_ready) begin
            mask_r[drain_col] <= 1'b1;
         end
      end
   end

   // program timer; fixed length stands for the worst-case cycle
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prog_cnt_r <= {CNT_W{1'b0}};
      end else if (ce) begin
         if (state_r != ST_PROG && state_nxt == ST_PROG) begin
            prog_cnt_r <= PROG_LOAD;
         end else if (state_r == ST_PROG && prog_cnt_r != {CNT_W{1'b0}}) begin
            prog_cnt_r <= prog_cnt_r - 1'b1;
         end
      end
   end

   // array update at the end of the cycle; only loaded columns change,
   // which gives partial page writes for free
   always @(posedge mclk) begin
      if (ce && commit) begin
         for (i = 0; i < `TWE_PAGE_BYTES; i = i + 1) begin
            if (mask_r[i]) begin
               mem_r[{row_r, i[`TWE_COL_W-1:0]}] <= page_r[i];
            end
         end
      end
   end

   // inspection read; latency one cycle
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_data_r <= `TWE_BYTE_RST;
      end else if (ce) begin
         rd_data_r <= mem_r[rd_addr];
      end
   end

endmodule

// *** tb/twe_props.sv ***
// concurrent checks on the pins of the two-wire write slave
`timescale 1ns/10ps
module twe_props #(
   parameter PROG_CYCLES = 400
) (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // serial pins
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   // status
   input wire standby_r,
   input wire busy_r,
   input wire read_mode_r
);
   localparam int LO_LIM = PROG_CYCLES - 1;
   localparam int HI_LIM = PROG_CYCLES + 8;
   int unsigned bcnt_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   // cycles spent in the current program cycle; a counter keeps long spans cheap
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bcnt_r <= 0;
      end else begin
         bcnt_r <= busy_r ? bcnt_r + 1 : 0;
      end
   end

   AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
      else $error("data pin drive value not low");
   AST_ACK_RISE_LOW: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("acknowledge began while clock high");
   AST_ACK_FALL_LOW: assert property ($fell(sda_oe) |-> !scl_in)
      else $error("acknowledge ended while clock high");
   AST_ACK_HOLD: assert property ($rose(sda_oe) |=> sda_oe [*8])
      else $error("acknowledge pulse too short");
   AST_NO_ACK_BUSY: assert property (busy_r |-> !sda_oe)
      else $error("acknowledge during program cycle");
   AST_BUSY_IDLE: assert property (busy_r |-> !standby_r && !read_mode_r)
      else $error("standby or read mode during program cycle");
   AST_PROG_START: assert property ($rose(busy_r) |-> scl_in && sda_in)
      else $error("program cycle started without stop");
   AST_PROG_MAX: assert property (busy_r |-> bcnt_r <= HI_LIM)
      else $error("program cycle too long");
   AST_PROG_MIN: assert property ($fell(busy_r) |-> bcnt_r >= LO_LIM)
      else $error("program cycle too short");
   AST_STANDBY_AFTER: assert property ($fell(busy_r) |-> ##[0:1] standby_r)
      else $error("no standby after program cycle");

   COV_PROG: cover property ($rose(busy_r));
   COV_READ: cover property ($rose(read_mode_r));
   COV_ACK: cover property ($rose(sda_oe));
endmodule

bind twe_slave twe_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (
   .mclk(mclk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .standby_r(standby_r), .busy_r(busy_r), .read_mode_r(read_mode_r)
);

// *** tb/twe_master.sv ***
// bus master model driving the two-wire serial pins
`timescale 1ns/10ps
module twe_master (
   // timing reference
   input  wire mclk,
   // serial pins, sda_low high pulls the data line
   output reg  scl,
   output reg  sda_low,
   input  wire sda
);
   // clock stands high outside frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task wt(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // one bit of 16 cycles; data moves mid low phase, clear of both clock edges
   task bit_io(input logic b, output logic seen);
      wt(5);
      sda_low = !b;
      wt(3);
      scl = 1'b1;
      wt(4);
      seen = sda;
      wt(4);
      scl = 1'b0;
   endtask

   task start();
      wt(5);
      sda_low = 1'b0;
      wt(3);
      scl = 1'b1;
      wt(8);
      sda_low = 1'b1;
      wt(8);
      scl = 1'b0;
   endtask

   task stop();
      wt(5);
      sda_low = 1'b1;
      wt(3);
      scl = 1'b1;
      wt(8);
      sda_low = 1'b0;
      wt(8);
   endtask

   // most significant bit first, then a released ninth bit for the acknowledge
   task wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = !s;
   endtask
endmodule

// *** tb/twe_slave_bench.sv ***
// self-checking bench of the two-wire write slave
`timescale 1ns/10ps
module twe_slave_bench;
   localparam int PROG = 400;
   localparam int LIMIT = 60000;
   logic        mclk, resetn, ce, wp, cs_hi, cs_lo, ack;
   logic        sda_out, sda_oe, standby_r, busy_r, read_mode_r;
   logic [8:0]  rd_addr;
   logic [7:0]  rd_data_r, d;
   logic [7:0]  exp_mem [0:511];
   logic [4:0]  row;
   logic [3:0]  col;
   logic [31:0] seed;
   wire         scl, sda_low, sda;
   int          n_mismatch = 0, check_count = 0, cyc = 0, n, it, k, t;

   // pull-up wire, low while either party pulls
   assign sda = (sda_oe || sda_low) ? 1'b0 : 1'b1;

   twe_slave #(.PROG_CYCLES(PROG)) i_dut (
      .mclk(mclk), .resetn(resetn), .ce(ce), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap_high(cs_hi),
      .chip_select_strap_low(cs_lo), .wp(wp), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
      .standby_r(standby_r), .busy_r(busy_r), .read_mode_r(read_mode_r)
   );
   twe_master i_mst (.mclk(mclk), .scl(scl), .sda_low(sda_low), .sda(sda));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [7:0] dev(input logic p, input logic rw);
      return {4'hA, cs_hi, cs_lo, p, rw};
   endfunction

   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t value %h expected %h", $time, seen, exp);
      end
   endtask

   task send(input logic [7:0] b, input logic e);
      i_mst.wbyte(b, ack);
      check({7'h00, ack}, {7'h00, e});
   endtask

   // bounded wait for the program cycle, plus one cycle for standby to land
   task wait_idle();
      n = 0;
      while (busy_r !== 1'b0 && n < 2000) begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
   endtask

   task report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      seed = 32'h0000F203;
      resetn = 1'b0;
      ce = 1'b1;
      wp = 1'b0;
      cs_hi = 1'b0;
      cs_lo = 1'b0;
      rd_addr = 9'h000;
      row = 5'h00;
      repeat (10) @(negedge mclk);
      check({5'h00, standby_r, busy_r, sda_oe}, 8'h04);
      resetn = 1'b1;
      repeat (4) @(negedge mclk);
      // single byte, wrapping page, protected page over the same row, random page
      for (it = 0; it < 4; it++) begin
         d = 8'(rnd());
         cs_hi = d[0];
         cs_lo = d[1];
         wp = (it == 2);
         d = 8'(rnd());
         if (it != 2) row = d[4:0];
         col = d[7:4];
         n = (it == 1) ? 19 : (it == 0) ? 1 : d[3:0] + 1;
         i_mst.start();
         send(dev(row[4], 1'b0), 1'b1);
         send({row[3:0], col}, 1'b1);
         for (k = 0; k < n; k++) begin
            d = 8'(rnd());
            send(d, 1'b1);
            if (!wp) exp_mem[{row, col + k[3:0]}] = d;
         end
         i_mst.stop();
         check({7'h00, busy_r}, {7'h00, !wp});
         if (!wp) begin
            i_mst.start();
            send(dev(1'b0, d[7]), 1'b0);
            i_mst.stop();
            wait_idle();
            check({7'h00, standby_r}, 8'h01);
         end
         i_mst.start();
         send(dev(row[4], 1'b0), 1'b1);
         i_mst.stop();
         check({7'h00, busy_r}, 8'h00);
         for (k = 0; k < 16; k++) begin
            rd_addr = {row, k[3:0]};
            @(negedge mclk);
            @(negedge mclk);
            if (!$isunknown(exp_mem[rd_addr])) check(rd_data_r, exp_mem[rd_addr]);
         end
      end
      // wrong prefix, each strap mismatched, then a matched read address
      wp = 1'b0;
      for (t = 0; t < 4; t++) begin
         d = dev(1'b0, t == 3);
         if (t == 0) d[4] = 1'b1;
         if (t == 1) d[3] = !cs_hi;
         if (t == 2) d[2] = !cs_lo;
         i_mst.start();
         send(d, t == 3);
         check({7'h00, read_mode_r}, {7'h00, t == 3});
         d = 8'(rnd());
         send(d, 1'b0);
         i_mst.stop();
         check({6'h00, standby_r, read_mode_r}, 8'h02);
      end
      // enable held low: a frozen slave must not answer even a matching address
      ce = 1'b0;
      i_mst.start();
      send(dev(1'b0, 1'b0), 1'b0);
      ce = 1'b1;
      i_mst.stop();
      check({6'h00, standby_r, busy_r}, 8'h02);
      report_and_stop();
   end
endmodule
